// *** design/atc_regs.svh ***
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH

// register byte offsets
`define ATC_OFS_CTRL 8'h00
`define ATC_OFS_SWTRIG 8'h04
`define ATC_OFS_DELAY 8'h08
`define ATC_OFS_DECIM 8'h0c
`define ATC_OFS_LINES 8'h10
`define ATC_OFS_STATUS 8'h14
`define ATC_OFS_LCOUNT 8'h18
`define ATC_OFS_BACKCNT 8'h1c
`define ATC_OFS_LAST 8'h1c

// control fields
`define ATC_CTRL_EN 0
`define ATC_CTRL_LINE 1
`define ATC_CTRL_DLY_EN 2
`define ATC_CTRL_DEC_EN 3
`define ATC_CTRL_END_LO 4
`define ATC_CTRL_END_HI 5
`define ATC_CTRL_DIR_SEL 6
`define ATC_CTRL_FILT_LO 7
`define ATC_CTRL_FILT_HI 8
`define ATC_CTRL_BMC 9
`define ATC_CTRL_SSEL_LO 10
`define ATC_CTRL_SSEL_HI 11
`define ATC_CTRL_ESEL_LO 12
`define ATC_CTRL_ESEL_HI 13

// software trigger bits
`define ATC_SW_START 0
`define ATC_SW_END 1

// status bits
`define ATC_STAT_DELAY 0
`define ATC_STAT_ACTIVE 1
`define ATC_STAT_FWD 2
`define ATC_STAT_SUSP 3

// end-of-acquisition and direction filter codes
`define ATC_END_FREE 2'h0
`define ATC_END_COUNT 2'h1
`define ATC_END_TRIG 2'h2
`define ATC_FILT_ANY 2'h0
`define ATC_FILT_FWD 2'h1
`define ATC_FILT_BWD 2'h2

// reset values
`define ATC_CTRL_RST 16'h0000
`define ATC_DELAY_RST 16'h0000
`define ATC_DECIM_RST 16'h0001
`define ATC_LINES_RST 16'h0100

// timing
`define ATC_CLK_NS 10
`define ATC_US_NS 1000

`endif

// *** design/atc_pkg.sv ***
`default_nettype none
package atc_pkg;

    typedef enum logic [1:0] {ATC_IDLE, ATC_DELAY, ATC_ACTIVE} atc_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } atc_apb_req_t;

    typedef struct packed {
        atc_state_t state;
        logic [15:0] ctrl;
        logic [15:0] delay;
        logic [15:0] decim;
        logic [15:0] lines;
        logic [31:0] prdata;
        logic tin_prev;
        logic ein_prev;
        logic [1:0] enc_prev;
        logic [15:0] dec_cnt;
        logic [15:0] dly_cnt;
        logic [15:0] line_cnt;
        logic [15:0] back_cnt;
        logic [6:0] pre_cnt;
        logic acq_start;
        logic line_trig;
        logic last_fwd;
    } atc_st_t;

endpackage

`default_nettype wire

// *** design/atc_trigger_ctrl.sv ***
// How it works
// R1: external line edge starts acquisition
// R2: software trigger starts acquisition too
// R3: area mode delays start in microseconds
// R4: decimation acts on every Nth external pulse
// R5: line mode ends freely, by count, or trigger
// R6: line mode delay counted in lines
// R7: web scanning emits every line, never stops
// R8: each object start trigger begins line run
// R9: decode phases A and B into direction
// R10: selector picks which phase order is forward
// R11: optional forward-only or backward-only lines
// R12: backward motion suspends lines at once
// R13: lines resume at exact suspend position
// R14: backward step counter must return to zero
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "atc_regs.svh"

module atc_trigger_ctrl #(
    parameter int N_LINES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire atc_pkg::atc_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N_LINES-1:0] trig_lines,
    input wire logic enc_a,
    input wire logic enc_b,
    output logic acq_start,
    output logic line_trig,
    output logic acq_active
);
    import atc_pkg::*;

    localparam int US_CYC = `ATC_US_NS / `ATC_CLK_NS;

    function automatic logic pick(input logic [N_LINES-1:0] v, input logic [1:0] sel);
        logic r;
        r = 1'b0;
        for (int i = 0; i < N_LINES; i++) begin
            if (2'(i) == sel) begin
                r = v[i];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] inc_sat(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    // delay counter reaches its target on this tick or step
    function automatic logic dly_last(input logic [15:0] cnt, input logic [15:0] target);
        return (cnt + 16'h0001) >= target;
    endfunction

    atc_st_t s, n;
    logic access, setup, mapped, sw_start, sw_end;
    logic tin_now, ein_now, ext_edge, end_edge, ext_ok, start_req, end_req;
    logic step, a_lead, fwd, fwd_step, bwd_step, line_ok, us_tick;
    logic [1:0] end_mode, filt;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        access = apb_req.psel & apb_req.penable;
        setup = apb_req.psel & ~apb_req.penable;
        mapped = (apb_req.paddr <= `ATC_OFS_LAST) && (apb_req.paddr[1:0] == 2'h0);
        sw_start = access & apb_req.pwrite & (apb_req.paddr == `ATC_OFS_SWTRIG)
            & apb_req.pwdata[`ATC_SW_START];
        sw_end = access & apb_req.pwrite & (apb_req.paddr == `ATC_OFS_SWTRIG)
            & apb_req.pwdata[`ATC_SW_END];
        end_mode = s.ctrl[`ATC_CTRL_END_HI:`ATC_CTRL_END_LO];
        filt = s.ctrl[`ATC_CTRL_FILT_HI:`ATC_CTRL_FILT_LO];
        tin_now = pick(trig_lines, s.ctrl[`ATC_CTRL_SSEL_HI:`ATC_CTRL_SSEL_LO]);
        ein_now = pick(trig_lines, s.ctrl[`ATC_CTRL_ESEL_HI:`ATC_CTRL_ESEL_LO]);
        ext_edge = tin_now & ~s.tin_prev; // [R1]
        end_edge = ein_now & ~s.ein_prev;
        ext_ok = ext_edge & (~s.ctrl[`ATC_CTRL_DEC_EN] | (s.dec_cnt == 16'h0000)); // [R4]
        start_req = s.ctrl[`ATC_CTRL_EN] & (ext_ok | sw_start) & (s.state == ATC_IDLE); // [R2]
        end_req = end_edge | sw_end;
        // one phase changed, the other held: a legal quadrature step
        step = (s.enc_prev[1] ^ enc_a) ^ (s.enc_prev[0] ^ enc_b); // [R9]
        a_lead = ~(s.enc_prev[1] ^ enc_b);
        fwd = a_lead ^ s.ctrl[`ATC_CTRL_DIR_SEL]; // [R10]
        fwd_step = step & fwd;
        bwd_step = step & ~fwd;
        if (s.ctrl[`ATC_CTRL_BMC]) begin
            line_ok = fwd_step & (s.back_cnt == 16'h0000); // [R12] [R13] [R14]
        end else if (filt == `ATC_FILT_FWD) begin
            line_ok = fwd_step; // [R11]
        end else if (filt == `ATC_FILT_BWD) begin
            line_ok = bwd_step; // [R11]
        end else begin
            line_ok = step;
        end
        // prescaler: area delay counts whole microseconds, not cycles
        us_tick = (s.pre_cnt == 7'(US_CYC - 1));
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = s;
        n.acq_start = 1'b0;
        n.line_trig = 1'b0;
        // prev flops reset low: a pin already high at release reads as an edge
        n.tin_prev = tin_now;
        n.ein_prev = ein_now;
        n.enc_prev = {enc_a, enc_b};
        if (step) begin
            n.last_fwd = fwd;
        end

        // register bus: read data captured in setup so the access needs no wait
        if (setup) begin
            case (apb_req.paddr)
                `ATC_OFS_CTRL: n.prdata = {16'h0000, s.ctrl};
                `ATC_OFS_DELAY: n.prdata = {16'h0000, s.delay};
                `ATC_OFS_DECIM: n.prdata = {16'h0000, s.decim};
                `ATC_OFS_LINES: n.prdata = {16'h0000, s.lines};
                `ATC_OFS_STATUS: begin
                    n.prdata = 32'h0000_0000;
                    n.prdata[`ATC_STAT_DELAY] = (s.state == ATC_DELAY);
                    n.prdata[`ATC_STAT_ACTIVE] = (s.state == ATC_ACTIVE);
                    n.prdata[`ATC_STAT_FWD] = s.last_fwd;
                    n.prdata[`ATC_STAT_SUSP] = (s.back_cnt != 16'h0000);
                end
                `ATC_OFS_LCOUNT: n.prdata = {16'h0000, s.line_cnt};
                `ATC_OFS_BACKCNT: n.prdata = {16'h0000, s.back_cnt};
                default: n.prdata = 32'h0000_0000;
            endcase
        end
        if (access & apb_req.pwrite) begin
            case (apb_req.paddr)
                `ATC_OFS_CTRL: n.ctrl = apb_req.pwdata[15:0];
                `ATC_OFS_DELAY: n.delay = apb_req.pwdata[15:0];
                `ATC_OFS_DECIM: n.decim = apb_req.pwdata[15:0];
                `ATC_OFS_LINES: n.lines = apb_req.pwdata[15:0];
                default: ;
            endcase
        end

        // decimation runs on every external edge, busy or not
        if (ext_edge & s.ctrl[`ATC_CTRL_DEC_EN]) begin
            n.dec_cnt = (inc_sat(s.dec_cnt) >= s.decim) ? 16'h0000 : inc_sat(s.dec_cnt); // [R4]
        end else if (!s.ctrl[`ATC_CTRL_DEC_EN]) begin
            n.dec_cnt = 16'h0000;
        end

        // backward steps are banked so lines resume where they stopped
        if (!s.ctrl[`ATC_CTRL_BMC]) begin
            n.back_cnt = 16'h0000;
        end else if (bwd_step) begin
            n.back_cnt = inc_sat(s.back_cnt); // [R12] [R14]
        end else if (fwd_step && s.back_cnt != 16'h0000) begin
            n.back_cnt = s.back_cnt - 16'h0001; // [R13] [R14]
        end

        case (s.state)
            ATC_IDLE: begin
                if (start_req) begin
                    n.dly_cnt = 16'h0000;
                    n.pre_cnt = 7'h00;
                    n.line_cnt = 16'h0000;
                    if (s.ctrl[`ATC_CTRL_DLY_EN] && s.delay != 16'h0000) begin
                        n.state = ATC_DELAY; // [R3] [R6]
                    end else if (s.ctrl[`ATC_CTRL_LINE]) begin
                        n.state = ATC_ACTIVE; // [R8]
                    end else begin
                        n.acq_start = 1'b1; // [R1] [R2]
                    end
                end
            end
            ATC_DELAY: begin
                if (!s.ctrl[`ATC_CTRL_LINE]) begin
                    n.pre_cnt = us_tick ? 7'h00 : s.pre_cnt + 7'h01;
                    if (us_tick) begin
                        n.dly_cnt = s.dly_cnt + 16'h0001;
                        if (dly_last(s.dly_cnt, s.delay)) begin
                            n.acq_start = 1'b1; // [R3]
                            n.state = ATC_IDLE;
                        end
                    end
                end else if (line_ok) begin
                    n.dly_cnt = s.dly_cnt + 16'h0001;
                    if (dly_last(s.dly_cnt, s.delay)) begin
                        n.state = ATC_ACTIVE; // [R6]
                    end
                end
            end
            ATC_ACTIVE: begin
                if (line_ok) begin
                    n.line_trig = 1'b1; // [R7]
                    n.line_cnt = inc_sat(s.line_cnt);
                    if (end_mode == `ATC_END_COUNT && inc_sat(s.line_cnt) >= s.lines) begin
                        n.state = ATC_IDLE; // [R5]
                    end
                end
                if (end_mode == `ATC_END_TRIG && end_req) begin
                    n.state = ATC_IDLE; // [R5]
                end
            end
            default: n.state = ATC_IDLE;
        endcase

        // clearing enable abandons any delay or line run
        if (!s.ctrl[`ATC_CTRL_EN]) begin
            n.state = ATC_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.state <= ATC_IDLE;
            s.ctrl <= `ATC_CTRL_RST;
            s.delay <= `ATC_DELAY_RST;
            s.decim <= `ATC_DECIM_RST;
            s.lines <= `ATC_LINES_RST;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = access;
    // bad address errors out and the write is dropped
    assign pslverr = access & ~mapped;
    assign acq_start = s.acq_start;
    assign line_trig = s.line_trig;
    assign acq_active = (s.state == ATC_ACTIVE);

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_a_leads;
        (!enc_a && !enc_b) ##1 (enc_a && !enc_b);
    endsequence

    sequence seq_idle_plain;
        s.state == ATC_IDLE && s.ctrl[`ATC_CTRL_EN] && !s.ctrl[`ATC_CTRL_DLY_EN];
    endsequence

    chk_sw_area_start: assert property ( // [R2]
        (seq_idle_plain and (sw_start && !s.ctrl[`ATC_CTRL_LINE])) |=> acq_start ##1 !acq_start)
        else $error("software trigger did not start area acquisition");
    chk_ext_area_start: assert property ( // [R1]
        (seq_idle_plain and (ext_ok && !s.ctrl[`ATC_CTRL_LINE])) |=> acq_start)
        else $error("external trigger did not start area acquisition");
    chk_us_delay_end: assert property ( // [R3]
        (s.state == ATC_DELAY && !s.ctrl[`ATC_CTRL_LINE] && s.ctrl[`ATC_CTRL_EN]
            && us_tick && s.dly_cnt + 16'h0001 >= s.delay) |=> acq_start && !acq_active)
        else $error("area delay did not end in a start pulse");
    chk_us_delay_hold: assert property ( // [R3]
        (s.state == ATC_DELAY && !s.ctrl[`ATC_CTRL_LINE] && !us_tick) |=> !acq_start)
        else $error("start pulse before the delay elapsed");
    chk_decim_skip: assert property ( // [R4]
        (s.state == ATC_IDLE && s.ctrl[`ATC_CTRL_DEC_EN] && ext_edge && s.dec_cnt != 16'h0000
            && !sw_start) |=> !acq_start && s.state == ATC_IDLE)
        else $error("decimated pulse was acted on");
    chk_count_end: assert property ( // [R5]
        (s.state == ATC_ACTIVE && end_mode == `ATC_END_COUNT && line_ok
            && inc_sat(s.line_cnt) >= s.lines) |=> line_trig && s.state == ATC_IDLE)
        else $error("line count did not end acquisition");
    chk_line_delay: assert property ( // [R6]
        (s.state == ATC_DELAY && s.ctrl[`ATC_CTRL_LINE] && s.ctrl[`ATC_CTRL_EN] && line_ok
            && s.dly_cnt + 16'h0001 >= s.delay) |=> acq_active && !line_trig)
        else $error("line delay did not open acquisition");
    chk_web_lines: assert property ( // [R7]
        (acq_active && s.ctrl[`ATC_CTRL_EN] && end_mode == `ATC_END_FREE && line_ok)
            |=> line_trig && acq_active)
        else $error("line dropped during web scanning");
    chk_object_start: assert property ( // [R8]
        (seq_idle_plain and (ext_ok && s.ctrl[`ATC_CTRL_LINE])) |=> acq_active)
        else $error("object trigger did not start lines");
    chk_dir_decode: assert property ( // [R9] [R10]
        seq_a_leads |=> s.last_fwd == !$past(s.ctrl[`ATC_CTRL_DIR_SEL]))
        else $error("phase order decoded to wrong direction");
    chk_fwd_only: assert property ( // [R11]
        (acq_active && !s.ctrl[`ATC_CTRL_BMC] && filt == `ATC_FILT_FWD && bwd_step)
            |=> !line_trig)
        else $error("line produced on excluded direction");
    chk_bmc_suspend: assert property ( // [R12] [R14]
        (acq_active && s.ctrl[`ATC_CTRL_BMC] && bwd_step && s.back_cnt != 16'hffff)
            |=> !line_trig && s.back_cnt == $past(s.back_cnt) + 16'h0001)
        else $error("backward motion did not suspend lines");
    chk_bmc_resume: assert property ( // [R13] [R14]
        (acq_active && s.ctrl[`ATC_CTRL_EN] && s.ctrl[`ATC_CTRL_BMC] && fwd_step
            && s.back_cnt == 16'h0001) |=> !line_trig && s.back_cnt == 16'h0000)
        else $error("resume happened before reaching suspend position");

    ////////////////////////////////////////////////////////////////////////
    // run boundaries
    chk_end_trig_stop: assert property ( // [R5]
        (acq_active && s.ctrl[`ATC_CTRL_EN] && end_mode == `ATC_END_TRIG && end_req)
            |=> !acq_active)
        else $error("end trigger did not stop acquisition");
    chk_idle_quiet: assert property ( // [R5]
        (s.state == ATC_IDLE && !start_req) |=> !line_trig && !acq_active)
        else $error("line or run without a start");
    chk_lcount_reset: assert property ( // [R5]
        (s.state == ATC_IDLE && start_req) |=> s.line_cnt == 16'h0000)
        else $error("line count not cleared at run start");
    chk_lines_in_run: assert property ( // [R7]
        line_trig |-> $past(s.state) == ATC_ACTIVE)
        else $error("line produced outside a run");
    chk_delay_no_line: assert property ( // [R6]
        (s.state == ATC_DELAY && s.ctrl[`ATC_CTRL_LINE]) |=> !line_trig)
        else $error("line produced during line delay");
    chk_enable_abort: assert property (
        !s.ctrl[`ATC_CTRL_EN] |=> !acq_active)
        else $error("run kept going with enable clear");
    chk_decim_wrap: assert property ( // [R4]
        (s.ctrl[`ATC_CTRL_DEC_EN] && ext_edge && inc_sat(s.dec_cnt) >= s.decim)
            |=> s.dec_cnt == 16'h0000)
        else $error("decimation counter did not wrap");
    // encoder path
    chk_bwd_only: assert property ( // [R11]
        (acq_active && !s.ctrl[`ATC_CTRL_BMC] && filt == `ATC_FILT_BWD && fwd_step)
            |=> !line_trig)
        else $error("line produced on excluded direction");
    chk_fwd_pass: assert property ( // [R11]
        (acq_active && s.ctrl[`ATC_CTRL_EN] && !s.ctrl[`ATC_CTRL_BMC]
            && filt == `ATC_FILT_FWD && fwd_step) |=> line_trig)
        else $error("forward step gave no line");
    chk_bmc_hold: assert property ( // [R12] [R14]
        (acq_active && s.ctrl[`ATC_CTRL_BMC] && fwd_step && s.back_cnt > 16'h0001)
            |=> !line_trig && s.back_cnt == $past(s.back_cnt) - 16'h0001)
        else $error("line given before suspend position reached");
    chk_bmc_line: assert property ( // [R13]
        (acq_active && s.ctrl[`ATC_CTRL_EN] && s.ctrl[`ATC_CTRL_BMC] && fwd_step
            && s.back_cnt == 16'h0000) |=> line_trig)
        else $error("no line after resume position reached");
    // register bus
    chk_status_active: assert property (
        (setup && apb_req.paddr == `ATC_OFS_STATUS)
            |=> prdata[`ATC_STAT_ACTIVE] == $past(acq_active))
        else $error("status did not report the run");

endmodule

`default_nettype wire

// *** verification/atc_far_side.sv ***
`timescale 1ns/1ps
`default_nettype none

module atc_far_side (
    input wire logic pclk,
    output logic [3:0] trig_lines,
    output logic enc_a,
    output logic enc_b
);
    int p = 0;

    initial begin
        trig_lines = '0;
        enc_a = 1'b0;
        enc_b = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // gray walk: only one phase moves per step, so direction is never ambiguous
    task automatic step(input bit lead_a);
        int h;
        h = 2 + $urandom % 4;
        @(posedge pclk);
        p = lead_a ? (p + 1) % 4 : (p + 3) % 4;
        enc_a <= (p == 1) || (p == 2);
        enc_b <= p >= 2;
        repeat (h) @(posedge pclk);
    endtask

    // sensor pulse, held long enough to be seen as one edge
    task automatic pulse(input int ln);
        @(posedge pclk);
        trig_lines[ln] <= 1'b1;
        repeat (3) @(posedge pclk);
        trig_lines[ln] <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// *** verification/test_acquisition_trigger_encoder_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "atc_regs.svh"

module test_acquisition_trigger_encoder_ctrl;
    import atc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    atc_apb_req_t req = '0;
    logic [31:0] prdata;
    logic pready, pslverr, acq_start, line_trig, acq_active, enc_a, enc_b;
    logic [3:0] trig;
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int checks = 0;
    int n_lines = 0;
    int n_starts = 0;
    int m_act, m_dly, m_left, m_back, m_lines, m_filt, m_bmc;
    bit m_dir;

    initial forever #5 pclk = ~pclk;

    atc_trigger_ctrl i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trig_lines(trig), .enc_a(enc_a), .enc_b(enc_b),
        .acq_start(acq_start), .line_trig(line_trig), .acq_active(acq_active));
    atc_far_side i_far (.pclk(pclk), .trig_lines(trig), .enc_a(enc_a), .enc_b(enc_b));

    always @(posedge pclk) begin
        if (line_trig === 1'b1) n_lines++;
        if (acq_start === 1'b1) n_starts++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // master never assumes a latency; the wait ends on pready or after 20 cycles
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            results();
        end
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0);
        chk(nm, rd, exp);
    endtask

    task automatic rst();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // reference model of the line path
    function automatic void mstep(bit f);
        if (m_act == 0) return;
        if (m_bmc != 0) begin
            if (!f) begin
                m_back++;
                return;
            end
            if (m_back != 0) begin
                m_back--;
                return;
            end
        end else if ((m_filt == 1 && !f) || (m_filt == 2 && f)) return;
        if (m_dly > 0) begin
            m_dly--;
            return;
        end
        m_lines++;
        if (m_left > 0 && --m_left == 0) m_act = 0;
    endfunction

    task automatic start(input int ln);
        i_far.pulse(ln);
        m_act = 1;
        if (m_dly == 0) chk("run active", acq_active, 1);
    endtask

    // encoder brought home first so a reset never sees a two-phase jump
    task automatic lcfg(input logic [15:0] c, input logic [31:0] nl, input logic [31:0] dl);
        while (i_far.p != 0) i_far.step(1'b1);
        rst();
        wr(`ATC_OFS_LINES, nl);
        wr(`ATC_OFS_DELAY, dl);
        wr(`ATC_OFS_CTRL, {16'h0, c});
        m_filt = c[8:7];
        m_bmc = c[9];
        m_dir = c[6];
        m_left = c[5:4] == 2'h1 ? nl : 0;
        m_dly = c[2] ? dl : 0;
        m_back = 0;
        m_lines = n_lines;
        start(c[11:10]);
    endtask

    task automatic steps(input bit la, input int n);
        for (int i = 0; i < n; i++) begin
            i_far.step(la);
            repeat (2) @(posedge pclk);
            mstep(la != m_dir);
            chk("lines", n_lines, m_lines);
            if (m_dly == 0) chk("active", acq_active, m_act);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int ln, n, base;
        logic [31:0] v;
        void'($urandom(32'h6a2ad45f));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk("ctrl", `ATC_OFS_CTRL, 32'h0);
        chk("slverr", err, 32'h0);
        rchk("decim", `ATC_OFS_DECIM, 32'h1);
        rchk("lines", `ATC_OFS_LINES, 32'h100);
        v = $urandom;
        wr(`ATC_OFS_DELAY, v);
        rchk("delay", `ATC_OFS_DELAY, {16'h0, v[15:0]});
        wr(`ATC_OFS_LCOUNT, 32'hffff);
        rchk("lcount ro", `ATC_OFS_LCOUNT, 32'h0);
        rchk("swtrig", `ATC_OFS_SWTRIG, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        $display("test registers finished");
        // area starts, hardware line picked at random
        rst();
        ln = $urandom % 4;
        wr(`ATC_OFS_CTRL, 32'h1 | (ln << 10));
        base = n_starts;
        i_far.pulse(ln);
        chk("hw start", n_starts - base, 1);
        wr(`ATC_OFS_SWTRIG, 32'h1);
        repeat (3) @(posedge pclk);
        chk("sw start", n_starts - base, 2);
        rst();
        wr(`ATC_OFS_DELAY, 32'h2);
        wr(`ATC_OFS_CTRL, 32'h5);
        base = n_starts;
        i_far.pulse(0);
        n = 7;
        while (n_starts == base && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk("delay", n >= 195 && n <= 208, 1);
        rst();
        wr(`ATC_OFS_DECIM, 32'h3);
        wr(`ATC_OFS_CTRL, 32'h9);
        base = n_starts;
        repeat (7) i_far.pulse(0);
        chk("decimation", n_starts - base, 3);
        $display("test area finished");
        lcfg(16'h0013, 5, 0);
        steps(1'b1, 7);
        rchk("lcount", `ATC_OFS_LCOUNT, 32'h5);
        lcfg(16'h0017, 4, 3);
        steps(1'b1, 9);
        lcfg(16'h0003, 1, 0);
        steps(1'b1, 10 + $urandom % 10);
        steps(1'b0, 3);
        lcfg(16'h2023, 1, 0);
        steps(1'b1, 3);
        i_far.pulse(2);
        m_act = 0;
        steps(1'b1, 2);
        start(0);
        steps(1'b1, 2);
        wr(`ATC_OFS_SWTRIG, 32'h2);
        m_act = 0;
        steps(1'b1, 2);
        $display("test line runs finished");
        for (int i = 0; i < 4; i++) begin
            lcfg({7'h0, 2'(i / 2 + 1), i[0], 6'h03}, 1, 0);
            steps(1'b1, 3);
            steps(1'b0, 3);
        end
        lcfg(16'h0203, 1, 0);
        steps(1'b1, 3);
        steps(1'b0, 2);
        rchk("backcnt", `ATC_OFS_BACKCNT, m_back);
        rchk("status susp", `ATC_OFS_STATUS, (1 << `ATC_STAT_ACTIVE) | (1 << `ATC_STAT_SUSP));
        steps(1'b1, 4);
        rchk("status fwd", `ATC_OFS_STATUS, (1 << `ATC_STAT_ACTIVE) | (1 << `ATC_STAT_FWD));
        $display("test direction finished");
        results();
    end
endmodule
`default_nettype wire
